// file: hdl/etu_top.sv
/*
 * Eight-timer unit with timer and edge interrupt flags, enables, priority
 * vector, watchdog restart pulse, run indicator and UART baud selection.
 * Assumes the processor byte bus and all pins are synchronous to clock,
 * and that bus strobes last one cycle per access.
 */
`timescale 1ns/10ps

//
// Contract
// - timer clock fall decrements low counter
// - low write updates low latch only
// - counter reads return live counters
// - low at zero on fall decrements high
// - rise with high zero: flag, reload
// - enabled set flag requests vectored interrupt
// - watchdog timeout pulls reset low eight cycles (two core cycles)
// - high write loads latch and both counters in the same cycle
// - watchdog idle until first timer0 run rise
// - timer0 run rise reloads; fall changes nothing
// - clock sources per timer, timer4 pin option
// - control bit0 picks timer4 pin clock
// - control bit1 drives timer4 output pin
// - control bits4-7 pick UART baud timer
// - run bit n gates timer n
// - enable registers plain storage gating flags
// - wait in native mode holds run low
// - level source set on edge, held low
// - edge source sets on configured transition
// - write one clears flag once only
// - highest address then bit wins vector
// - timer n sets timer flag bit n
// - timer enable register same bit order
module etu_top
    import etu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // processor byte bus
    input wire etu_bus_s bus,
    output logic [7:0] rdData,
    // interrupt request to the core
    output etu_irq_s irq,
    input wire logic waitForIrq,
    input wire logic emulationMode,
    output logic runPin,
    // interrupt sources
    input wire logic externalIrqRequestInN,
    input wire logic [NUM_EDGE-1:0] edgeSrcIn,
    // system reset pin, open drain
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOeN,
    // timer 4 pins and baud ticks
    input wire logic t4ExtClockPin,
    output logic t4OutputPin,
    output logic t4OutputOeN,
    output logic [NUM_UARTS-1:0] uartBaudTick
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] highBit(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // ----------------------------------------------------------------
    // clock divider
    // ----------------------------------------------------------------
    logic [DIV_WIDTH-1:0] divCnt;
    logic [DIV_WIDTH-1:0] next_divCnt;

    always_comb begin
        next_divCnt = divCnt + DIV_WIDTH'(1);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            divCnt <= '0;
        end else begin
            divCnt <= next_divCnt;
        end
    end

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] run;
    logic [NUM_TIMERS-1:0] tclk;
    logic [NUM_TIMERS-1:0] expired;
    logic [NUM_TIMERS-1:0] wrLo;
    logic [NUM_TIMERS-1:0] wrHi;
    logic [NUM_TIMERS-1:0] reload;
    logic [7:0] cntHi [NUM_TIMERS];
    logic [7:0] cntLo [NUM_TIMERS];
    logic prevRun0;
    logic run0Rise;

    assign run0Rise = run[WATCHDOG_TIMER] && !prevRun0;

    always_comb begin
        tclk = {NUM_TIMERS{divCnt[FAST_TAP]}};
        tclk[0] = divCnt[CORE_TAP];
        tclk[1] = divCnt[CORE_TAP];
        tclk[2] = divCnt[FAST16_TAP];
        if (ctrl[T4_CLOCK_PIN_SELECT]) begin
            tclk[BAUD_TIMER_B] = t4ExtClockPin;
        end
    end

    genvar n;
    generate
        for (n = 0; n < NUM_TIMERS; n++) begin : g_timer
            localparam logic [15:0] LO_ADDR = TCNT_BASE + 16'(2 * n);
            localparam logic [15:0] HI_ADDR = TCNT_BASE + 16'(2 * n + 1);
            assign wrLo[n] = bus.wr && bus.addr == LO_ADDR;
            assign wrHi[n] = bus.wr && bus.addr == HI_ADDR;
            assign reload[n] = (n == WATCHDOG_TIMER) ? run0Rise : 1'b0;
            etu_timer u_timer (
                .clock(clock),
                .rst_n(rst_n),
                .tclk(tclk[n]),
                .run(run[n]),
                .reload(reload[n]),
                .wrLo(wrLo[n]),
                .wrHi(wrHi[n]),
                .wrData(bus.data),
                .cntHi(cntHi[n]),
                .cntLo(cntLo[n]),
                .expired(expired[n])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // registers and flags
    // ----------------------------------------------------------------
    logic [7:0] tien;
    logic [7:0] eien;
    logic [7:0] tflag;
    logic [7:0] eflag;
    logic [NUM_EDGE-1:0] prevEdge;
    logic prevIrqN;
    logic [7:0] next_ctrl;
    logic [7:0] next_run;
    logic [7:0] next_tien;
    logic [7:0] next_eien;
    logic [7:0] next_tflag;
    logic [7:0] next_eflag;
    logic [7:0] next_rdData;
    logic [7:0] edgeSet;
    logic [7:0] tClr;
    logic [7:0] eClr;

    always_comb begin
        next_ctrl = ctrl;
        next_run = run;
        next_tien = tien;
        next_eien = eien;
        tClr = '0;
        eClr = '0;
        if (bus.wr) begin
            case (bus.addr)
                CTRL_ADDR: next_ctrl = bus.data;
                RUN_ADDR: next_run = bus.data;
                TIEN_ADDR: next_tien = bus.data;
                EIEN_ADDR: next_eien = bus.data;
                TFLAG_ADDR: tClr = bus.data;
                EFLAG_ADDR: eClr = bus.data;
                default: ;
            endcase
        end
        for (int k = 0; k < NUM_EDGE; k++) begin
            edgeSet[k] = EDGE_RISE_MASK[k] ? (edgeSrcIn[k] && !prevEdge[k])
                                           : (!edgeSrcIn[k] && prevEdge[k]);
        end
        edgeSet[LEVEL_SOURCE_BIT] = !externalIrqRequestInN
                                    && (prevIrqN || eflag[LEVEL_SOURCE_BIT]);
        next_tflag = (tflag & ~tClr) | expired;
        next_eflag = (eflag & ~eClr) | edgeSet;
        next_rdData = rdData;
        if (bus.rd) begin
            next_rdData = 8'h00;
            case (bus.addr)
                CTRL_ADDR: next_rdData = ctrl;
                RUN_ADDR: next_rdData = run;
                TFLAG_ADDR: next_rdData = tflag;
                EIEN_ADDR: next_rdData = eien;
                TIEN_ADDR: next_rdData = tien;
                EFLAG_ADDR: next_rdData = eflag;
                default: ;
            endcase
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (bus.addr == TCNT_BASE + 16'(2 * t)) begin
                    next_rdData = cntLo[t];
                end
                if (bus.addr == TCNT_BASE + 16'(2 * t + 1)) begin
                    next_rdData = cntHi[t];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl <= REG_RST;
            run <= REG_RST;
            tien <= REG_RST;
            eien <= REG_RST;
            tflag <= REG_RST;
            eflag <= REG_RST;
            prevRun0 <= 1'b0;
            prevEdge <= '0;
            prevIrqN <= 1'b1;
            rdData <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            run <= next_run;
            tien <= next_tien;
            eien <= next_eien;
            tflag <= next_tflag;
            eflag <= next_eflag;
            prevRun0 <= run[WATCHDOG_TIMER];
            prevEdge <= edgeSrcIn;
            prevIrqN <= externalIrqRequestInN;
            rdData <= next_rdData;
        end
    end

    // ----------------------------------------------------------------
    // interrupt request and run indicator
    // ----------------------------------------------------------------
    logic [7:0] tPend;
    logic [7:0] ePend;
    etu_irq_s next_irq;
    logic next_runPin;

    always_comb begin
        tPend = tflag & tien;
        ePend = eflag & eien;
        next_irq.req = (tPend != 8'h00) || (ePend != 8'h00);
        if (ePend != 8'h00) begin
            next_irq.vector = {1'b1, highBit(ePend)};
        end else begin
            next_irq.vector = {1'b0, highBit(tPend)};
        end
        next_runPin = runPin;
        if (waitForIrq && !emulationMode) begin
            next_runPin = 1'b0;
        end
        if (next_irq.req) begin
            next_runPin = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq <= '0;
            runPin <= 1'b1;
        end else begin
            irq <= next_irq;
            runPin <= next_runPin;
        end
    end

    // ----------------------------------------------------------------
    // watchdog restart
    // ----------------------------------------------------------------
    logic wdActive;
    logic [3:0] rstCnt;
    logic next_wdActive;
    logic [3:0] next_rstCnt;
    logic next_resetPinOeN;

    always_comb begin
        next_wdActive = wdActive;
        next_rstCnt = rstCnt;
        if (run0Rise) begin
            next_wdActive = 1'b1;
        end
        if (!resetPinIn) begin
            next_wdActive = 1'b0;
        end
        if (rstCnt != 4'h0) begin
            next_rstCnt = rstCnt - 4'h1;
        end else if (wdActive && expired[WATCHDOG_TIMER]) begin
            next_rstCnt = RESET_PULSE_CYC;
            next_wdActive = 1'b0;
        end
        next_resetPinOeN = (next_rstCnt == 4'h0);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wdActive <= 1'b0;
            rstCnt <= 4'h0;
            resetPinOeN <= 1'b1;
            resetPinOut <= 1'b0;
        end else begin
            wdActive <= next_wdActive;
            rstCnt <= next_rstCnt;
            resetPinOeN <= next_resetPinOeN;
            resetPinOut <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // timer 4 pin and baud ticks
    // ----------------------------------------------------------------
    logic next_t4OutputPin;
    logic next_t4OutputOeN;
    logic [NUM_UARTS-1:0] next_uartBaudTick;

    always_comb begin
        next_t4OutputPin = t4OutputPin ^ expired[BAUD_TIMER_B];
        next_t4OutputOeN = !ctrl[T4_OUTPUT_PIN_ENABLE];
        for (int u = 0; u < NUM_UARTS; u++) begin
            next_uartBaudTick[u] = ctrl[UART_BAUD_SELECT_LSB + u]
                                   ? expired[BAUD_TIMER_B] : expired[BAUD_TIMER_A];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            t4OutputPin <= 1'b0;
            t4OutputOeN <= 1'b1;
            uartBaudTick <= '0;
        end else begin
            t4OutputPin <= next_t4OutputPin;
            t4OutputOeN <= next_t4OutputOeN;
            uartBaudTick <= next_uartBaudTick;
        end
    end

endmodule

// file: inc/etu_pkg.sv
/*
 * Shared constants and types for the eight-timer unit: register addresses,
 * field positions, reset values, clock taps and bus/interrupt carriers.
 * Assumes a single 100 MHz system clock; slower rates come from taps of
 * a free-running divider.
 */
package etu_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] CTRL_ADDR = 16'hDF42;
    localparam logic [15:0] RUN_ADDR = 16'hDF43;
    localparam logic [15:0] TFLAG_ADDR = 16'hDF44;
    localparam logic [15:0] EIEN_ADDR = 16'hDF45;
    localparam logic [15:0] TIEN_ADDR = 16'hDF46;
    localparam logic [15:0] EFLAG_ADDR = 16'hDF47;
    // timer n low counter at base + 2n, high counter at base + 2n + 1
    localparam logic [15:0] TCNT_BASE = 16'hDF60;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int T4_CLOCK_PIN_SELECT = 0;
    localparam int T4_OUTPUT_PIN_ENABLE = 1;
    localparam int PULSE_MEASURE_MODE_LO = 2;
    localparam int PULSE_MEASURE_MODE_HI = 3;
    localparam int UART_BAUD_SELECT_LSB = 4;
    localparam int WATCHDOG_TIMER = 0;
    localparam int BAUD_TIMER_A = 3;
    localparam int BAUD_TIMER_B = 4;
    localparam int LEVEL_SOURCE_BIT = 7;
    localparam int NUM_TIMERS = 8;
    localparam int NUM_UARTS = 4;
    localparam int NUM_EDGE = 7;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'hFF;
    localparam logic [7:0] COUNT_RST = 8'hFF;
    // 1 = edge source fires on rising transition, 0 = falling
    localparam logic [6:0] EDGE_RISE_MASK = 7'h05;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIV_WIDTH = 5;
    localparam int FAST_TAP = 0;
    localparam int CORE_TAP = 1;
    localparam int FAST16_TAP = FAST_TAP + 4;
    localparam int CORE_PERIOD_NS = CLK_PERIOD_NS * (2 ** (CORE_TAP + 1));
    localparam int CORE_CYC = CORE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RESET_CORE_CYCLES = 2;
    localparam logic [3:0] RESET_PULSE_CYC = 4'(RESET_CORE_CYCLES * CORE_CYC);

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } etu_bus_s;

    typedef struct packed {
        logic req;
        logic [3:0] vector;
    } etu_irq_s;

endpackage

// file: hdl/etu_timer.sv
/*
 * One 16-bit down-counter: high and low byte counters with reload latches.
 * Assumes tclk is a level synchronous to clock; its edges are found here.
 */
`timescale 1ns/10ps

module etu_timer
    import etu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // timer clock and control
    input wire logic tclk,
    input wire logic run,
    input wire logic reload,
    // processor writes
    input wire logic wrLo,
    input wire logic wrHi,
    input wire logic [7:0] wrData,
    // state
    output logic [7:0] cntHi,
    output logic [7:0] cntLo,
    output logic expired
);

    logic prevClk;
    logic [7:0] latchHi;
    logic [7:0] latchLo;
    logic next_prevClk;
    logic [7:0] next_latchHi;
    logic [7:0] next_latchLo;
    logic [7:0] next_cntHi;
    logic [7:0] next_cntLo;
    logic next_expired;

    always_comb begin
        next_prevClk = tclk;
        next_latchHi = latchHi;
        next_latchLo = latchLo;
        next_cntHi = cntHi;
        next_cntLo = cntLo;
        next_expired = 1'b0;
        if (run && prevClk && !tclk) begin
            next_cntLo = cntLo - 8'h01;
            if (cntLo == 8'h00) begin
                next_cntHi = cntHi - 8'h01;
            end
        end
        if (run && !prevClk && tclk && cntHi == 8'h00) begin
            next_expired = 1'b1;
            next_cntHi = latchHi;
            next_cntLo = latchLo;
        end
        if (wrLo) begin
            next_latchLo = wrData;
        end
        if (wrHi) begin
            next_latchHi = wrData;
            next_cntHi = wrData;
            next_cntLo = latchLo;
        end else if (reload) begin
            next_cntHi = latchHi;
            next_cntLo = latchLo;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prevClk <= 1'b0;
            latchHi <= LATCH_RST;
            latchLo <= LATCH_RST;
            cntHi <= COUNT_RST;
            cntLo <= COUNT_RST;
            expired <= 1'b0;
        end else begin
            prevClk <= next_prevClk;
            latchHi <= next_latchHi;
            latchLo <= next_latchLo;
            cntHi <= next_cntHi;
            cntLo <= next_cntLo;
            expired <= next_expired;
        end
    end

endmodule

// file: bench/etu_top_props.sv
/*
 * Port-level assertions for etu_top.
 * Assumes the bind at the foot of this file and one clock domain.
 */
`timescale 1ns/10ps

module etu_top_props
    import etu_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus and core
    input wire etu_bus_s bus,
    input wire logic [7:0] rdData,
    input wire etu_irq_s irq,
    input wire logic waitForIrq,
    input wire logic emulationMode,
    input wire logic runPin,
    // pins
    input wire logic resetPinOut,
    input wire logic resetPinOeN,
    input wire logic t4OutputOeN
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // register shadows
    // ----------------------------------------------------------------
    logic [7:0] runShadow;
    logic [7:0] tienShadow;
    logic [7:0] tienPrev;
    logic [7:0] next_runShadow;
    logic [7:0] next_tienShadow;

    always_comb begin
        next_runShadow = runShadow;
        next_tienShadow = tienShadow;
        if (bus.wr && bus.addr == RUN_ADDR)
            next_runShadow = bus.data;
        if (bus.wr && bus.addr == TIEN_ADDR)
            next_tienShadow = bus.data;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            runShadow <= REG_RST;
            tienShadow <= REG_RST;
            tienPrev <= REG_RST;
        end else begin
            runShadow <= next_runShadow;
            tienShadow <= next_tienShadow;
            tienPrev <= tienShadow;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_pulse_low;
        !resetPinOeN [*8];
    endsequence

    a_reset_drive_low: assert property (resetPinOut == 1'b0)
        else $error("reset pin driven high");
    a_wdog_pulse_len: assert property ($fell(resetPinOeN) |-> s_pulse_low ##1 resetPinOeN)
        else $error("reset pulse length wrong");
    a_wdog_needs_arm: assert property ($fell(resetPinOeN) |-> runShadow[WATCHDOG_TIMER])
        else $error("reset pulse while watchdog idle");
    a_t4_pin_enable: assert property (bus.wr && bus.addr == CTRL_ADDR |->
        ##2 (t4OutputOeN == !$past(bus.data[T4_OUTPUT_PIN_ENABLE], 2)))
        else $error("timer 4 output enable wrong");
    a_run_readback: assert property (bus.rd && bus.addr == RUN_ADDR |=> rdData == runShadow)
        else $error("run register read wrong");
    a_tien_readback: assert property (bus.rd && bus.addr == TIEN_ADDR |=> rdData == tienShadow)
        else $error("enable register read wrong");
    a_irq_enabled: assert property (irq.req && !irq.vector[3] |-> tienPrev[irq.vector[2:0]])
        else $error("timer interrupt without enable");
    a_wait_lowers: assert property (waitForIrq && !emulationMode && !irq.req |=> !runPin || irq.req)
        else $error("run indicator not lowered");
    a_wake_on_irq: assert property (irq.req |-> runPin)
        else $error("run indicator not raised");
    a_emul_ignores: assert property (waitForIrq && emulationMode && runPin |=> runPin)
        else $error("wait honoured in emulation mode");
endmodule

bind etu_top etu_top_props u_props (
    .clock(clock),
    .rst_n(rst_n),
    .bus(bus),
    .rdData(rdData),
    .irq(irq),
    .waitForIrq(waitForIrq),
    .emulationMode(emulationMode),
    .runPin(runPin),
    .resetPinOut(resetPinOut),
    .resetPinOeN(resetPinOeN),
    .t4OutputOeN(t4OutputOeN)
);

// file: bench/etu_cpu_model.sv
/*
 * Processor core model: byte bus master and reset pin pull-up.
 * Assumes one access per call, strobes changed on falling edges.
 */
`timescale 1ns/10ps

module etu_cpu_model
    import etu_pkg::*;
(
    // clock
    input wire logic clock,
    // bus side
    output etu_bus_s bus,
    input wire logic [7:0] rdData,
    input wire etu_irq_s irq,
    // reset pin, pulled up
    input wire logic resetPinOut,
    input wire logic resetPinOeN,
    output logic resetLevel
);
    assign resetLevel = resetPinOeN ? 1'b1 : resetPinOut;

    initial bus = '0;

    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        bus <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
        @(negedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
        @(negedge clock);
        bus <= '{addr: a, data: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clock);
        bus.rd <= 1'b0;
        @(posedge clock);
        #1 d = rdData;
    endtask

    // reload low then high before running
    task automatic load_timer(input int n, input logic [15:0] v);
        bus_write(TCNT_BASE + 16'(2 * n), v[7:0]);
        bus_write(TCNT_BASE + 16'(2 * n + 1), v[15:8]);
    endtask

    task automatic service_timer;
        bus_write(TFLAG_ADDR, 8'h01 << irq.vector[2:0]);
    endtask
endmodule

// file: bench/tb_top.sv
/*
 * Self-checking bench for etu_top.
 * Assumes the core model drives the bus and resolves the reset pin.
 */
`timescale 1ns/10ps

module tb_top
    import etu_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n;
    etu_bus_s bus;
    logic [7:0] rdData;
    etu_irq_s irq;
    logic waitForIrq;
    logic emulationMode;
    logic runPin;
    logic externalIrqRequestInN;
    logic resetLevel;
    logic resetPinOut;
    logic resetPinOeN;
    logic t4OutputOeN;
    logic [3:0] uartBaudTick;
    logic [3:0] seenTicks;
    logic tickClr;
    logic [6:0] edgeSrc;
    logic t4Clk;
    logic t4Out;
    int mismatches = 0;
    int numChecks = 0;

    always #5 clock = ~clock;
    always @(posedge clock) seenTicks <= tickClr ? 4'h0 : seenTicks | uartBaudTick;

    etu_top DUT (
        .clock(clock), .rst_n(rst_n), .bus(bus), .rdData(rdData), .irq(irq),
        .waitForIrq(waitForIrq), .emulationMode(emulationMode), .runPin(runPin),
        .externalIrqRequestInN(externalIrqRequestInN), .edgeSrcIn(edgeSrc),
        .resetPinIn(resetLevel), .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
        .t4ExtClockPin(t4Clk), .t4OutputPin(t4Out), .t4OutputOeN(t4OutputOeN),
        .uartBaudTick(uartBaudTick)
    );

    etu_cpu_model cpu (
        .clock(clock), .bus(bus), .rdData(rdData), .irq(irq),
        .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN), .resetLevel(resetLevel)
    );

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic wrap_up;
        if (mismatches == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        cpu.bus_read(a, d);
        check(d, exp);
    endtask

    task automatic pulse_wait;
        @(negedge clock);
        waitForIrq = 1'b1;
        @(negedge clock);
        waitForIrq = 1'b0;
        @(negedge clock);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d;
        int k;
        rst_n = 1'b0;
        waitForIrq = 1'b0;
        emulationMode = 1'b0;
        externalIrqRequestInN = 1'b1;
        tickClr = 1'b1;
        edgeSrc = 7'h00;
        t4Clk = 1'b0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        for (k = 0; k < 6; k++) rdchk(CTRL_ADDR + 16'(k), REG_RST);
        rdchk(TCNT_BASE + 16'hA, COUNT_RST);
        check({7'h00, runPin}, 8'h01);
        check({7'h00, t4OutputOeN}, 8'h01);
        // baud selection and pin enable
        cpu.bus_write(CTRL_ADDR, 8'h52);
        rdchk(CTRL_ADDR, 8'h52);
        check({7'h00, t4OutputOeN}, 8'h00);
        cpu.load_timer(3, 16'h0000);
        @(negedge clock);
        tickClr = 1'b0;
        cpu.bus_write(RUN_ADDR, 8'h08);
        repeat (8) @(negedge clock);
        check({4'h0, seenTicks}, 8'h0A);
        cpu.bus_write(RUN_ADDR, 8'h00);
        cpu.bus_write(CTRL_ADDR, 8'h00);
        rdchk(CTRL_ADDR, 8'h00);
        check({7'h00, t4OutputOeN}, 8'h01);
        cpu.bus_write(16'hDF48, 8'h77);
        rdchk(16'hDF48, 8'h00);
        // latch and counter access on a stopped timer
        cpu.bus_write(TCNT_BASE + 16'hA, 8'h34);
        rdchk(TCNT_BASE + 16'hA, 8'hFF);
        cpu.bus_write(TCNT_BASE + 16'hB, 8'h12);
        rdchk(TCNT_BASE + 16'hA, 8'h34);
        rdchk(TCNT_BASE + 16'hB, 8'h12);
        // countdown, expiry, reload, priority
        cpu.bus_write(TFLAG_ADDR, 8'hFF);
        cpu.bus_write(TIEN_ADDR, 8'h44);
        rdchk(TIEN_ADDR, 8'h44);
        cpu.load_timer(2, 16'h0100);
        cpu.load_timer(6, 16'h0000);
        cpu.bus_write(RUN_ADDR, 8'h44);
        d = 8'h00;
        for (k = 0; k < 40 && d[2] !== 1'b1; k++) cpu.bus_read(TFLAG_ADDR, d);
        if (d[2] !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
        rdchk(TCNT_BASE + 16'h4, 8'h00);
        rdchk(TCNT_BASE + 16'h5, 8'h01);
        repeat (16) @(negedge clock);
        rdchk(TCNT_BASE + 16'h4, 8'hFF);
        rdchk(TCNT_BASE + 16'h5, 8'h00);
        cpu.bus_write(RUN_ADDR, 8'h00);
        check({3'h0, irq.req, irq.vector}, 8'h16);
        cpu.service_timer();
        rdchk(TFLAG_ADDR, 8'h04);
        check({3'h0, irq.req, irq.vector}, 8'h12);
        cpu.bus_write(TFLAG_ADDR, 8'h00);
        rdchk(TFLAG_ADDR, 8'h04);
        cpu.bus_write(TFLAG_ADDR, 8'h04);
        rdchk(TFLAG_ADDR, 8'h00);
        check({7'h00, irq.req}, 8'h00);
        // wait instruction and level source
        emulationMode = 1'b1;
        pulse_wait();
        check({7'h00, runPin}, 8'h01);
        emulationMode = 1'b0;
        pulse_wait();
        check({7'h00, runPin}, 8'h00);
        cpu.bus_write(EIEN_ADDR, 8'h80);
        externalIrqRequestInN = 1'b0;
        for (k = 0; k < 20 && runPin !== 1'b1; k++) @(negedge clock);
        check({7'h00, runPin}, 8'h01);
        check({3'h0, irq.req, irq.vector}, 8'h1F);
        cpu.bus_write(EFLAG_ADDR, 8'h80);
        rdchk(EFLAG_ADDR, 8'h80);
        externalIrqRequestInN = 1'b1;
        cpu.bus_write(EFLAG_ADDR, 8'h80);
        rdchk(EFLAG_ADDR, 8'h00);
        // edge sources: bit0 fires rising, bit1 falling
        @(negedge clock);
        edgeSrc = 7'h03;
        rdchk(EFLAG_ADDR, 8'h01);
        @(negedge clock);
        edgeSrc = 7'h00;
        rdchk(EFLAG_ADDR, 8'h03);
        cpu.bus_write(EFLAG_ADDR, 8'h03);
        // timer 4 clocked from its pin
        cpu.bus_write(CTRL_ADDR, 8'h03);
        cpu.load_timer(4, 16'h0001);
        cpu.bus_write(RUN_ADDR, 8'h10);
        repeat (4) @(negedge clock);
        check({7'h00, t4Out}, 8'h00);
        t4Clk = 1'b1;
        repeat (2) @(negedge clock);
        check({7'h00, t4Out}, 8'h01);
        cpu.bus_write(RUN_ADDR, 8'h00);
        // watchdog arming and restart pulse
        cpu.load_timer(0, 16'h0001);
        check({7'h00, resetLevel}, 8'h01);
        cpu.bus_write(RUN_ADDR, 8'h01);
        for (k = 0; k < 20 && resetLevel !== 1'b0; k++) @(negedge clock);
        for (k = 0; k < 20 && resetLevel === 1'b0; k++) @(negedge clock);
        check(8'(k), 8'(RESET_PULSE_CYC));
        wrap_up();
    end
endmodule
